//--- design/frs_pkg.sv
package frs_pkg;
    // wishbone register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_KEY = 8'h04;
    localparam logic [7:0] ADDR_PAGE = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0c;
    localparam logic [7:0] ADDR_LATCH = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // control register fields
    localparam int OP_LSB = 0;
    localparam int OP_W = 6;
    localparam int ERASE_BIT = 6;
    localparam int ARM_BIT = 14;
    localparam int START_BIT = 15;
    localparam logic [5:0] OP_ROW_ERASE = 6'h18;
    localparam logic [5:0] OP_ROW_PROGRAM = 6'h04;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam int ROW_WORDS = 32;
    localparam int ROW_AW = 5;
    localparam int INSTR_W = 24;
    localparam int PAGE_W = 8;
    // cycle times
    localparam int ERASE_TIME_US = 2;
    localparam int PROGRAM_TIME_US = 2;
    localparam int CLK_MHZ = 100;
    localparam logic [15:0] ERASE_CYCLES = 16'(ERASE_TIME_US * CLK_MHZ);
    localparam logic [15:0] PROGRAM_CYCLES = 16'(PROGRAM_TIME_US * CLK_MHZ);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROGRAM = 3'b100
    } frs_state_t;
endpackage

//--- design/frs_latch_if.sv
interface frs_latch_if;
    import frs_pkg::*;
    logic program_arm_bit;
    logic [ROW_AW-1:0] wrIdx;
    logic [INSTR_W-1:0] wrData;
    logic [ROW_AW-1:0] rdIdx;
    logic [INSTR_W-1:0] rdData;
    modport owner (output program_arm_bit, output wrIdx, output wrData, output rdIdx, input rdData);
    modport mem (input program_arm_bit, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

//--- design/frs_row_latch.sv
// row write latches: one instruction per slot, read data registered
module frs_row_latch
    import frs_pkg::*;
(
    input wire logic clk,
    frs_latch_if.mem lat
);
    logic [INSTR_W-1:0] mem [ROW_WORDS];
    logic [INSTR_W-1:0] rdq;

    // no reset: latch contents are undefined until software loads them
    always_ff @(posedge clk) begin
        if (lat.program_arm_bit) begin
            mem[lat.wrIdx] <= lat.wrData;
        end
        rdq <= mem[lat.rdIdx];
    end
    assign lat.rdData = rdq;
endmodule

//--- design/frs_sequencer.sv
// What this block does
// [R1] erase and program work on whole rows of 32 instructions
// [R2] control bits 5..0 select operation; 011000 means row erase
// [R3] software sets erase-select and write-enable before a row erase; code ignores erase-select (bit 6)
// [R4] software gives row address as page register plus in-page offset
// [R5] software writes 55h then AAh to key register just before start
// [R6] start bit begins erase and stalls the processor until done
// [R7] start bit clears itself when the erase ends
// [R8] software loads 32 instructions into the write latches first
// [R9] programming uses op 000100, erase-select clear, write-enable set; the code does not check erase-select (bit 6)
// [R10] start bit begins programming, stalls processor, clears when done
// [R11] no erase or program without the key sequence first
// [R12] software follows the start with two no-operations
// [R13] any other write after the second key disarms the sequence; writes to unmapped addresses do not disarm here
// [R14] start ignored while write-enable is clear; flash left untouched
module frs_sequencer
    import frs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic cpuStall,
    output logic flashEraseRow,
    output logic flashProgramWord,
    output logic [frs_pkg::PAGE_W-1:0] flashPage,
    output logic [15:0] flashOffset,
    output logic [frs_pkg::ROW_AW-1:0] flashWordIdx,
    output logic [frs_pkg::INSTR_W-1:0] flashData
);
    import frs_pkg::*;

    typedef struct packed {
        frs_state_t state;
        logic [15:0] control;
        logic [PAGE_W-1:0] page;
        logic [15:0] offset;
        logic [ROW_AW-1:0] loadIdx;
        logic keyFirstSeen;
        logic armed;
        logic [15:0] timer;
        logic [ROW_AW-1:0] progIdx;
        logic progFetched;
        logic [31:0] datOut;
        logic ack;
        logic err;
        logic stall;
        logic eraseStrobe;
        logic progStrobe;
        logic [ROW_AW-1:0] outIdx;
        logic [INSTR_W-1:0] outData;
        logic doneCount;
    } frs_regs_t;

    frs_regs_t r;
    frs_regs_t next_r;
    frs_latch_if lat ();

    frs_row_latch u_latch (
        .clk(clk),
        .lat(lat)
    );

    logic busReq;
    logic wrReq;
    logic rdReq;
    logic mapped;
    logic keyWrite;
    logic ctrlWrite;
    logic startReq;
    logic [5:0] opSel;

    // a request is served once; ack drops the cycle after it is given
    always_comb begin
        busReq = wb_cyc_i & wb_stb_i & ~r.ack & ~r.err;
        mapped = (wb_adr_i == ADDR_CONTROL) | (wb_adr_i == ADDR_KEY) | (wb_adr_i == ADDR_PAGE)
               | (wb_adr_i == ADDR_OFFSET) | (wb_adr_i == ADDR_LATCH) | (wb_adr_i == ADDR_STATUS);
        wrReq = busReq & wb_we_i & mapped;
        rdReq = busReq & ~wb_we_i & mapped;
        keyWrite = wrReq & (wb_adr_i == ADDR_KEY) & wb_sel_i[0];
        ctrlWrite = wrReq & (wb_adr_i == ADDR_CONTROL) & wb_sel_i[1];
        startReq = ctrlWrite & wb_dat_i[START_BIT];
        opSel = wb_sel_i[0] ? wb_dat_i[OP_LSB +: OP_W] : r.control[OP_LSB +: OP_W];
    end

    // latch writes come straight from the bus; programming reads walk the row
    always_comb begin
        lat.program_arm_bit = wrReq & (wb_adr_i == ADDR_LATCH) & (r.state == ST_IDLE);
        lat.wrIdx = r.loadIdx;
        lat.wrData = wb_dat_i[INSTR_W-1:0];
        lat.rdIdx = r.progIdx;
    end

    // main sequencer: bus slave, key unlock, erase/program timing
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.err = 1'b0;
        next_r.eraseStrobe = 1'b0;
        next_r.progStrobe = 1'b0;
        if (busReq) begin
            next_r.ack = mapped;
            next_r.err = ~mapped;
        end
        // any mapped write other than a key write breaks the unlock chain
        if (wrReq & ~keyWrite) begin
            next_r.keyFirstSeen = 1'b0;
            next_r.armed = 1'b0; // [R13]
        end
        if (keyWrite) begin
            // 55h then AAh, back to back, arms one start [R5]
            next_r.keyFirstSeen = (wb_dat_i[7:0] == KEY_FIRST);
            next_r.armed = r.keyFirstSeen & (wb_dat_i[7:0] == KEY_SECOND);
        end
        if (rdReq) begin
            case (wb_adr_i)
                ADDR_CONTROL: next_r.datOut = {16'h0000, r.control};
                ADDR_PAGE: next_r.datOut = {24'h000000, r.page};
                ADDR_OFFSET: next_r.datOut = {16'h0000, r.offset};
                ADDR_STATUS: next_r.datOut = {25'h0000000, r.loadIdx, r.armed, r.stall};
                default: next_r.datOut = 32'h00000000; // key and latches read as zero
            endcase
        end
        if (r.state == ST_IDLE) begin
            if (wrReq & (wb_adr_i == ADDR_PAGE) & wb_sel_i[0]) begin
                next_r.page = wb_dat_i[PAGE_W-1:0]; // [R4]
            end
            if (wrReq & (wb_adr_i == ADDR_OFFSET)) begin
                if (wb_sel_i[0]) next_r.offset[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) next_r.offset[15:8] = wb_dat_i[15:8];
                next_r.loadIdx = wb_dat_i[ROW_AW:1]; // latch slot follows the offset
            end
            if (lat.program_arm_bit) begin
                next_r.loadIdx = r.loadIdx + ROW_AW'(1); // [R8]
            end
            if (ctrlWrite | (wrReq & (wb_adr_i == ADDR_CONTROL))) begin
                if (wb_sel_i[0]) next_r.control[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) next_r.control[14:8] = wb_dat_i[14:8];
                next_r.control[START_BIT] = 1'b0;
                next_r.keyFirstSeen = 1'b0;
                next_r.armed = 1'b0; // one unlock per start attempt
                // start only with unlock and write-enable [R11] [R14]
                if (startReq & r.armed & wb_dat_i[ARM_BIT]) begin
                    if (opSel == OP_ROW_ERASE) begin // [R2]
                        next_r.control[START_BIT] = 1'b1;
                        next_r.state = ST_ERASE; // [R6]
                        next_r.stall = 1'b1;
                        next_r.timer = ERASE_CYCLES;
                        next_r.eraseStrobe = 1'b1; // [R1]
                        next_r.outIdx = '0;
                    end else if (opSel == OP_ROW_PROGRAM) begin
                        next_r.control[START_BIT] = 1'b1;
                        next_r.state = ST_PROGRAM; // [R10]
                        next_r.stall = 1'b1;
                        next_r.timer = PROGRAM_CYCLES;
                        next_r.progIdx = '0;
                        next_r.progFetched = 1'b0;
                        next_r.doneCount = 1'b0;
                    end
                end
            end
        end
        case (r.state)
            ST_IDLE: begin
            end
            ST_ERASE: begin
                next_r.timer = r.timer - 16'h0001;
                if (r.timer == 16'h0001) begin
                    next_r.state = ST_IDLE;
                    next_r.stall = 1'b0;
                    next_r.control[START_BIT] = 1'b0; // [R7]
                end
            end
            ST_PROGRAM: begin
                // hand all 32 latch slots to the array, then wait the write time
                if (~r.doneCount) begin
                    next_r.progFetched = 1'b1;
                    if (r.progFetched) begin
                        next_r.progStrobe = 1'b1; // [R1]
                        next_r.outIdx = r.progIdx;
                        next_r.outData = lat.rdData;
                        next_r.progIdx = r.progIdx + ROW_AW'(1);
                        next_r.progFetched = 1'b0;
                        next_r.doneCount = (r.progIdx == ROW_AW'(ROW_WORDS - 1));
                    end
                end else begin
                    next_r.timer = r.timer - 16'h0001;
                    if (r.timer == 16'h0001) begin
                        next_r.state = ST_IDLE;
                        next_r.stall = 1'b0;
                        next_r.control[START_BIT] = 1'b0; // [R10]
                    end
                end
            end
            default: next_r.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{state: ST_IDLE, control: CONTROL_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_o = r.datOut;
    assign wb_ack_o = r.ack;
    assign wb_err_o = r.err;
    assign cpuStall = r.stall;
    assign flashEraseRow = r.eraseStrobe;
    assign flashProgramWord = r.progStrobe;
    assign flashPage = r.page;
    assign flashOffset = r.offset;
    assign flashWordIdx = r.outIdx;
    assign flashData = r.outData;

    // start bit set by hardware is only held while the processor is stalled
    chk_start_stall: assert property (@(posedge clk) disable iff (reset) // [R6]
        r.control[START_BIT] |-> r.stall)
        else $error("start bit set without stall");
    chk_no_unlocked_start: assert property (@(posedge clk) disable iff (reset) // [R11]
        (ctrlWrite & r.state == ST_IDLE & ~r.armed) |=> (r.state == ST_IDLE))
        else $error("operation began without unlock");
    // a control write while busy is ignored anyway, so only idle writes count here
    chk_arm_needed: assert property (@(posedge clk) disable iff (reset) // [R14]
        (ctrlWrite & ~wb_dat_i[ARM_BIT] & (r.state == ST_IDLE)) |=> ~r.eraseStrobe & (r.state == ST_IDLE))
        else $error("start accepted with write-enable clear");
    chk_disarm_other: assert property (@(posedge clk) disable iff (reset) // [R13]
        (wrReq & ~keyWrite & ~ctrlWrite) |=> ~r.armed)
        else $error("stray write kept unlock");
    chk_erase_len: assert property (@(posedge clk) disable iff (reset) // [R6]
        r.eraseStrobe |-> r.stall [*8])
        else $error("erase stall too short");
    chk_erase_clear: assert property (@(posedge clk) disable iff (reset) // [R7]
        (r.state == ST_ERASE && r.timer == 16'h0001) |=> ~r.control[START_BIT] & ~r.stall)
        else $error("start bit not cleared after erase");
    chk_prog_clear: assert property (@(posedge clk) disable iff (reset) // [R10]
        (r.state == ST_PROGRAM && r.doneCount && r.timer == 16'h0001) |=> ~r.control[START_BIT])
        else $error("start bit not cleared after program");
    chk_erase_op: assert property (@(posedge clk) disable iff (reset) // [R2]
        $rose(r.state == ST_ERASE) |-> $past(opSel) == OP_ROW_ERASE)
        else $error("erase with wrong op");
    chk_key_order: assert property (@(posedge clk) disable iff (reset) // [R5]
        $rose(r.armed) |-> $past(r.keyFirstSeen))
        else $error("armed without first key");

    // stall, busy state and start bit must never drift apart
    chk_stall_busy: assert property (@(posedge clk) disable iff (reset) // [R6]
        r.stall == (r.state != ST_IDLE))
        else $error("stall differs from busy state");
    chk_busy_start: assert property (@(posedge clk) disable iff (reset) // [R6]
        (r.state != ST_IDLE) |-> r.control[START_BIT])
        else $error("busy without start bit");
    chk_erase_timer: assert property (@(posedge clk) disable iff (reset) // [R6]
        r.eraseStrobe |-> (r.timer == ERASE_CYCLES))
        else $error("erase timer not loaded");
    chk_erase_single: assert property (@(posedge clk) disable iff (reset) // [R1]
        r.eraseStrobe |=> ~r.eraseStrobe)
        else $error("erase strobe longer than one cycle");
    chk_stall_fall: assert property (@(posedge clk) disable iff (reset) // [R7]
        $fell(r.stall) |-> ~r.control[START_BIT])
        else $error("stall released with start bit set");
    chk_addr_hold: assert property (@(posedge clk) disable iff (reset) // [R6]
        (r.state != ST_IDLE) |=> $stable(r.page) && $stable(r.offset))
        else $error("row address moved while busy");

    // programming walks the whole row once, in order, then waits the write time
    chk_prog_op: assert property (@(posedge clk) disable iff (reset) // [R10]
        $rose(r.state == ST_PROGRAM) |-> $past(opSel) == OP_ROW_PROGRAM)
        else $error("program with wrong op");
    chk_prog_first: assert property (@(posedge clk) disable iff (reset) // [R1]
        $rose(r.state == ST_PROGRAM) |-> (r.progIdx == '0) & ~r.doneCount)
        else $error("program did not start at slot zero");
    chk_prog_timer: assert property (@(posedge clk) disable iff (reset) // [R10]
        (r.state == ST_PROGRAM & ~r.doneCount) |-> (r.timer == PROGRAM_CYCLES))
        else $error("write time ran before the row was sent");
    chk_word_busy: assert property (@(posedge clk) disable iff (reset) // [R1]
        r.progStrobe |-> (r.state == ST_PROGRAM))
        else $error("word strobe outside programming");
    chk_last_word: assert property (@(posedge clk) disable iff (reset) // [R1]
        (r.progStrobe & (r.outIdx == ROW_AW'(ROW_WORDS - 1))) |-> r.doneCount)
        else $error("last word did not end the row");
    chk_idle_quiet: assert property (@(posedge clk) disable iff (reset) // [R11]
        (r.state == ST_IDLE) |=> ~r.progStrobe)
        else $error("word strobe while idle");

    // a start must have been unlocked and enabled in the cycle it was taken
    chk_start_armed: assert property (@(posedge clk) disable iff (reset) // [R11]
        $rose(r.stall) |-> $past(r.armed))
        else $error("stall began without unlock");
    chk_start_enabled: assert property (@(posedge clk) disable iff (reset) // [R14]
        $rose(r.stall) |-> $past(wb_dat_i[ARM_BIT]))
        else $error("stall began with write-enable clear");
    chk_key_disarm: assert property (@(posedge clk) disable iff (reset) // [R13]
        (keyWrite & (wb_dat_i[7:0] != KEY_SECOND)) |=> ~r.armed)
        else $error("wrong key kept unlock");
    // an ignored control write during a cycle still counts as an intervening write
    chk_busy_disarm: assert property (@(posedge clk) disable iff (reset) // [R13]
        (ctrlWrite & (r.state != ST_IDLE)) |=> ~r.armed)
        else $error("busy control write kept unlock");
endmodule

//--- test/frs_flash_model.sv
// far side: one row of the flash array fed by the sequencer's erase and word strobes
module frs_flash_model
    import frs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic eraseRow,
    input wire logic programWord,
    input wire logic [ROW_AW-1:0] wordIdx,
    input wire logic [INSTR_W-1:0] data,
    output logic [7:0] eraseCount,
    output logic [7:0] wordCount,
    output logic orderOk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [INSTR_W-1:0] row [ROW_WORDS];

    // cells only clear bits when programmed, so a row that skipped its erase reads back wrong
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eraseCount <= 8'h00;
            wordCount <= 8'h00;
            orderOk <= 1'b1;
        end else begin
            if (eraseRow) begin
                eraseCount <= eraseCount + 8'h01;
                for (int i = 0; i < ROW_WORDS; i++) row[i] <= '1;
            end
            if (programWord) begin
                row[wordIdx] <= row[wordIdx] & data;
                wordCount <= wordCount + 8'h01;
                if (wordIdx !== wordCount[ROW_AW-1:0]) orderOk <= 1'b0;
            end
        end
    end
endmodule

//--- test/test_frs_sequencer.sv
module test_frs_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import frs_pkg::*;
    logic clk, reset, wbCyc, wbStb, wbWe, wbAck, wbErr, cpuStall, eraseRow, progWord, er, orderOk;
    logic [7:0] wbAdr, eraseCount, wordCount, flashPage;
    logic [3:0] wbSel;
    logic [31:0] wbDat, wbDatO, rd;
    logic [15:0] flashOffset;
    logic [ROW_AW-1:0] wordIdx;
    logic [INSTR_W-1:0] flashData;
    int fails = 0;
    int compares = 0;
    int stallN;

    frs_sequencer u_dut (.clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .wb_err_o(wbErr), .cpuStall(cpuStall), .flashEraseRow(eraseRow), .flashProgramWord(progWord),
        .flashPage(flashPage), .flashOffset(flashOffset), .flashWordIdx(wordIdx), .flashData(flashData));
    frs_flash_model u_flash (.clk(clk), .reset(reset), .eraseRow(eraseRow), .programWord(progWord),
        .wordIdx(wordIdx), .data(flashData), .eraseCount(eraseCount), .wordCount(wordCount), .orderOk(orderOk));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; entered just after an edge, leaves one idle cycle behind it
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hf;
        wbAdr <= adr;
        wbDat <= dat;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
        rd = wbDatO;
        er = wbErr;
        if (n >= 50) fails++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat);
    endtask

    task automatic keys();
        wr(ADDR_KEY, 32'(KEY_FIRST));
        wr(ADDR_KEY, 32'(KEY_SECOND));
    endtask

    // bounded wait for the stall to drop; the count shows how long the cycle ran
    task automatic wait_idle();
        stallN = 0;
        while (cpuStall === 1'b1 && stallN < 2000) begin
            @(posedge clk);
            stallN++;
        end
    endtask

    function automatic logic [INSTR_W-1:0] exp_word(input int i);
        return INSTR_W'(i * 24'h030507 + 24'h000100);
    endfunction

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        {wbCyc, wbStb, wbWe} = 3'b000;
        {wbAdr, wbDat, wbSel} = {8'h00, 32'h0, 4'hf};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset value, then an unmapped address
        wb(1'b0, ADDR_CONTROL, 32'h0);
        check("control reset", rd, 32'(CONTROL_RESET));
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped err", 32'(er), 32'h1);
        // start with no unlock at all, then unlocked but not armed
        wr(ADDR_CONTROL, 32'h0000c058);
        @(posedge clk);
        check("stall no key", 32'(cpuStall), 32'h0);
        wr(ADDR_CONTROL, 32'h00000058);
        keys();
        wr(ADDR_CONTROL, 32'h00008058);
        @(posedge clk);
        check("stall no arm", 32'(cpuStall), 32'h0);
        // a stray write between the second key and the start disarms
        keys();
        wb(1'b0, ADDR_STATUS, 32'h0);
        check("armed", rd & 32'h2, 32'h2);
        wr(ADDR_PAGE, 32'h00000012);
        wr(ADDR_CONTROL, 32'h0000c058);
        @(posedge clk);
        check("stall stray", 32'(cpuStall), 32'h0);
        check("no erase yet", 32'(eraseCount), 32'h0);
        // row erase at the last latch slot offset
        wr(ADDR_OFFSET, 32'h0000003e);
        wb(1'b0, ADDR_STATUS, 32'h0);
        check("latch index", rd, 32'h0000007c);
        wr(ADDR_CONTROL, 32'h00004058);
        keys();
        wr(ADDR_CONTROL, 32'h0000c058);
        @(posedge clk);
        check("erase stall", 32'(cpuStall), 32'h1);
        check("erase pulse", 32'(eraseCount), 32'h1);
        wb(1'b0, ADDR_CONTROL, 32'h0);
        check("start busy", rd & 32'h8000, 32'h8000);
        // unlock and an ignored control write while busy: that write must still disarm
        keys();
        wr(ADDR_CONTROL, 32'h00004058);
        wait_idle();
        check("erase time", 32'(stallN > ERASE_CYCLES - 32 && stallN < ERASE_CYCLES), 32'h1);
        wb(1'b0, ADDR_CONTROL, 32'h0);
        check("start clear", rd & 32'h8000, 32'h0);
        check("row page", 32'(flashPage), 32'h12);
        check("row offset", 32'(flashOffset), 32'h3e);
        wr(ADDR_CONTROL, 32'h0000c004);
        @(posedge clk);
        check("stall busy write", 32'(cpuStall), 32'h0);
        // fill the latches with a whole row and program it
        wr(ADDR_OFFSET, 32'h0);
        for (int i = 0; i < ROW_WORDS; i++) wr(ADDR_LATCH, 32'(exp_word(i)));
        wr(ADDR_CONTROL, 32'h00004004);
        keys();
        wr(ADDR_CONTROL, 32'h0000c004);
        @(posedge clk);
        check("program stall", 32'(cpuStall), 32'h1);
        wait_idle();
        check("program time", 32'(stallN > PROGRAM_CYCLES && stallN < PROGRAM_CYCLES + 2 * ROW_WORDS + 8), 32'h1);
        check("words sent", 32'(wordCount), 32'(ROW_WORDS));
        check("word order", 32'(orderOk), 32'h1);
        wb(1'b0, ADDR_CONTROL, 32'h0);
        check("program clear", rd & 32'h8000, 32'h0);
        for (int i = 0; i < ROW_WORDS; i++) check("row data", 32'(u_flash.row[i]), 32'(exp_word(i)));
        check("one erase", 32'(eraseCount), 32'h1);
        summarize();
    end
endmodule
